// *** include/mcd_defs.svh ***
// Purpose: constants of the 14-bit instruction decoder and executer
// Assumes: byte addresses on a 32-bit APB, 20 MHz mclk_i
// Notes: definitions only
// How it works
// - 00 prefix: op code, destination, file address
// - 01 prefix: bit clear, set, test-skips
// - 11 prefix: literal operations on low byte
// - 10 prefix: call or jump, two cycles
// - fixed control words under 00 0000
// - destination bit picks work or file
// - move file sets zero, self-move tests zero
// - load literal leaves flags untouched
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - return with literal loads work, pops stack
// - subroutine return pops stack, two cycles
// - interrupt return pops, sets interrupt enable
// - standby clears watchdog, sets timeout, stops
// - port self-modify reads the pins
// - timer-zero write clears its prescaler when PSA is 0
// - pc change or true skip costs two
// - arithmetic sets c, dc, z; logic, clear, inc, dec, move file z
// - watchdog clear: one cycle, sets flags
// - move work to file, no flags
`ifndef MCD_DEFS_SVH
`define MCD_DEFS_SVH

// register offsets (byte addresses)
`define MCD_OFS_CTRL 8'h00
`define MCD_OFS_STATUS 8'h04
`define MCD_OFS_PC 8'h08
`define MCD_OFS_WDT 8'h0c

// control register fields and reset value
`define MCD_CTRL_RUN 0
`define MCD_CTRL_PSA 1
`define MCD_CTRL_WAKE 2
`define MCD_CTRL_GIE_CLR 3
`define MCD_CTRL_RESET 2'h0

// status register fields
`define MCD_ST_C 8
`define MCD_ST_DC 9
`define MCD_ST_Z 10
`define MCD_ST_TO 11
`define MCD_ST_PD 12
`define MCD_ST_GIE 13
`define MCD_ST_STANDBY 14
`define MCD_ST_RUNNING 15

// instruction classes (top two bits)
`define MCD_CLS_BYTE 2'h0
`define MCD_CLS_BIT 2'h1
`define MCD_CLS_BRANCH 2'h2
`define MCD_CLS_LIT 2'h3

// byte-oriented op codes
`define MCD_OP_CTL 4'h0
`define MCD_OP_CLR 4'h1
`define MCD_OP_SUB 4'h2
`define MCD_OP_DEC 4'h3
`define MCD_OP_IOR 4'h4
`define MCD_OP_AND 4'h5
`define MCD_OP_XOR 4'h6
`define MCD_OP_ADD 4'h7
`define MCD_OP_MOV 4'h8
`define MCD_OP_COM 4'h9
`define MCD_OP_INC 4'ha
`define MCD_OP_DECSZ 4'hb
`define MCD_OP_RRC 4'hc
`define MCD_OP_RLC 4'hd
`define MCD_OP_SWAP 4'he
`define MCD_OP_INCSZ 4'hf

// control low bytes under 00 0000
`define MCD_CW_STANDBY 8'h63
`define MCD_CW_RETURN 8'h08
`define MCD_CW_IRET 8'h09
`define MCD_CW_WDTCLR 8'h64

// special file addresses, reset values
`define MCD_TIMER_ZERO_COUNT_ADDR 7'h01
`define MCD_PORT_BASE 7'h05
`define MCD_PC_RESET 13'h0000
`define MCD_NOP_WORD 14'h0000

// timing
`define MCD_CLK_NS 50
`define MCD_TCY_NS 200
`define MCD_CLKS_PER_TCY (`MCD_TCY_NS / `MCD_CLK_NS)

`endif

// *** include/mcd_pkg.sv ***
// Purpose: types of the instruction decoder
// Assumes: nothing
// Notes: constants live in mcd_defs.svh
package mcd_pkg;
  typedef enum logic [1:0] {
    MCD_HALT,
    MCD_RUN,
    MCD_STANDBY
  } mcd_state_e;
endpackage : mcd_pkg

// *** hw/mcd_core.sv ***
// Purpose: decode and execute 14-bit instruction words, APB control
// Assumes: program memory and file space answer combinationally to registered addresses
// Notes: one instruction cycle is four mclk_i cycles
`timescale 1ns/100ps
`include "mcd_defs.svh"

module mcd_core
  import mcd_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int PORT_COUNT = 5
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [12:0] pm_addr_o,
  input wire logic [13:0] pm_data_i,
  output logic [6:0] file_addr_o,
  input wire logic [7:0] file_rdata_i,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  input wire logic [PORT_COUNT*8-1:0] port_pins_i,
  output logic timer_zero_count_presc_clr_o,
  output logic osc_stop_o,
  output logic global_interrupt_enable_o
);

  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int TCY = `MCD_CLKS_PER_TCY;

  // refuse parameter values the logic cannot serve
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("STACK_DEPTH must be a power of two, at least 2");
  end
  if (PORT_COUNT < 1 || PORT_COUNT > 8) begin : g_bad_ports
    $error("PORT_COUNT must be 1 to 8");
  end
  if (TCY != 4) begin : g_bad_tcy
    $error("instruction cycle must be four clocks");
  end

  // state
  mcd_state_e state_q;
  logic [1:0] ph_q;
  logic [12:0] pc_q;
  logic [13:0] instr_q;
  logic [7:0] opnd_q, w_q;
  logic c_q, dc_q, z_q, to_q, pd_q, gie_q, flush_q;
  logic [12:0] stack_q [STACK_DEPTH];
  logic [SPW-1:0] sp_q;
  logic [7:0] wdt_q, wdt_presc_q;
  logic run_q, psa_q;
  logic [PORT_COUNT*8-1:0] pin_meta_q, pin_sync_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, file_we_q, timer_zero_count_clr_q, stop_q;
  logic [6:0] file_addr_q;
  logic [7:0] file_wdata_q;

  // instruction fields
  wire [1:0] cls = instr_q[13:12];
  wire [3:0] op = instr_q[11:8];
  wire dest = instr_q[7];
  wire [6:0] faddr = instr_q[6:0];
  wire [7:0] lit = instr_q[7:0];
  wire [2:0] bitn = instr_q[9:7];
  wire [7:0] bmask = 8'h01 << bitn;

  // phase ticks
  wire tick_fetch = (state_q == MCD_RUN) && (ph_q == 2'h1);
  wire tick_read = (state_q == MCD_RUN) && (ph_q == 2'h2);
  wire tick_exec = (state_q == MCD_RUN) && (ph_q == 2'h3);

  // port addresses take the synchronised pin levels
  wire [6:0] port_off = faddr - `MCD_PORT_BASE;
  wire is_port = (faddr >= `MCD_PORT_BASE) && (port_off < 7'(PORT_COUNT));
  wire [2:0] port_idx = port_off[2:0];
  wire [7:0] pin_byte = pin_sync_q[port_idx*8 +: 8];
  wire [7:0] src_byte = is_port ? pin_byte : file_rdata_i;

  // APB decode
  wire apb_setup = psel_i & ~penable_i;
  wire apb_done = psel_i & penable_i & pready_q;
  wire wr_ctrl = apb_done & pwrite_i & (paddr_i == `MCD_OFS_CTRL);
  wire hit = (paddr_i == `MCD_OFS_CTRL) || (paddr_i == `MCD_OFS_STATUS)
          || (paddr_i == `MCD_OFS_PC) || (paddr_i == `MCD_OFS_WDT);
  wire wake_req = wr_ctrl & pwdata_i[`MCD_CTRL_WAKE];
  wire gie_clr = wr_ctrl & pwdata_i[`MCD_CTRL_GIE_CLR];
  wire [31:0] status_word = {16'h0000, state_q == MCD_RUN, state_q == MCD_STANDBY, gie_q,
                             pd_q, to_q, z_q, dc_q, c_q, w_q};
  wire [31:0] rd_mux =
      (paddr_i == `MCD_OFS_CTRL) ? {30'h0, psa_q, run_q} :
      (paddr_i == `MCD_OFS_STATUS) ? status_word :
      (paddr_i == `MCD_OFS_PC) ? {16'h0, 3'(sp_q), pc_q} :
      (paddr_i == `MCD_OFS_WDT) ? {16'h0, wdt_presc_q, wdt_q} : 32'h0;

  // execute: results of the current word
  logic [7:0] res, ea, eb;
  logic wr_w, wr_f, upd_z, upd_cdc, upd_c, c_new, dc_new, skip;
  logic do_call, do_jump, do_pop, set_gie, go_standby, wdt_clr, sub_sel;
  logic [8:0] sum9;
  logic [4:0] sum5;

  always_comb begin
    res = 8'h00;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    upd_c = 1'b0;
    c_new = c_q;
    dc_new = dc_q;
    skip = 1'b0;
    do_call = 1'b0;
    do_jump = 1'b0;
    do_pop = 1'b0;
    set_gie = 1'b0;
    go_standby = 1'b0;
    wdt_clr = 1'b0;
    // adder operands: file or literal first, work second
    ea = (cls == `MCD_CLS_LIT) ? lit : opnd_q;
    sub_sel = (cls == `MCD_CLS_LIT) ? (op[3:1] == 3'b110) : (op == `MCD_OP_SUB);
    eb = sub_sel ? ~w_q : w_q;
    sum9 = {1'b0, ea} + {1'b0, eb} + {8'h00, sub_sel};
    sum5 = {1'b0, ea[3:0]} + {1'b0, eb[3:0]} + {4'h0, sub_sel};
    case (cls)
      `MCD_CLS_BYTE: begin
        wr_w = ~dest;
        wr_f = dest;
        upd_z = 1'b1;
        case (op)
          `MCD_OP_CTL: begin
            wr_w = 1'b0;
            wr_f = 1'b0;
            upd_z = 1'b0;
            if (dest) begin
              res = w_q;
              wr_f = 1'b1;
            end else if (lit == `MCD_CW_STANDBY) begin
              go_standby = 1'b1;
              wdt_clr = 1'b1;
            end else if (lit == `MCD_CW_RETURN) begin
              do_pop = 1'b1;
            end else if (lit == `MCD_CW_IRET) begin
              do_pop = 1'b1;
              set_gie = 1'b1;
            end else if (lit == `MCD_CW_WDTCLR) begin
              wdt_clr = 1'b1;
            end
            // 0xx0 0000 and every other pattern do nothing
          end
          `MCD_OP_CLR: res = 8'h00;
          `MCD_OP_SUB, `MCD_OP_ADD: begin
            res = sum9[7:0];
            upd_cdc = 1'b1;
            c_new = sum9[8];
            dc_new = sum5[4];
          end
          `MCD_OP_DEC: res = opnd_q - 8'h01;
          `MCD_OP_IOR: res = opnd_q | w_q;
          `MCD_OP_AND: res = opnd_q & w_q;
          `MCD_OP_XOR: res = opnd_q ^ w_q;
          `MCD_OP_MOV: res = opnd_q;
          `MCD_OP_COM: res = ~opnd_q;
          `MCD_OP_INC: res = opnd_q + 8'h01;
          `MCD_OP_DECSZ, `MCD_OP_INCSZ: begin
            res = (op == `MCD_OP_DECSZ) ? opnd_q - 8'h01 : opnd_q + 8'h01;
            upd_z = 1'b0;
            skip = (res == 8'h00);
          end
          `MCD_OP_RRC: begin
            res = {c_q, opnd_q[7:1]};
            upd_z = 1'b0;
            upd_c = 1'b1;
            c_new = opnd_q[0];
          end
          `MCD_OP_RLC: begin
            res = {opnd_q[6:0], c_q};
            upd_z = 1'b0;
            upd_c = 1'b1;
            c_new = opnd_q[7];
          end
          `MCD_OP_SWAP: begin
            res = {opnd_q[3:0], opnd_q[7:4]};
            upd_z = 1'b0;
          end
          default: upd_z = 1'b0;
        endcase
      end
      `MCD_CLS_BIT: begin
        case (op[3:2])
          2'b00: begin
            res = opnd_q & ~bmask;
            wr_f = 1'b1;
          end
          2'b01: begin
            res = opnd_q | bmask;
            wr_f = 1'b1;
          end
          2'b10: skip = ((opnd_q & bmask) == 8'h00);
          default: skip = ((opnd_q & bmask) != 8'h00);
        endcase
      end
      `MCD_CLS_BRANCH: begin
        do_call = ~instr_q[11];
        do_jump = instr_q[11];
      end
      default: begin
        wr_w = 1'b1;
        upd_z = 1'b1;
        casez (op)
          4'b00??: begin
            res = lit;
            upd_z = 1'b0;
          end
          4'b01??: begin
            res = lit;
            upd_z = 1'b0;
            do_pop = 1'b1;
          end
          4'b1000: res = lit | w_q;
          4'b1001: res = lit & w_q;
          4'b1010: res = lit ^ w_q;
          4'b110?, 4'b111?: begin
            res = sum9[7:0];
            upd_cdc = 1'b1;
            c_new = sum9[8];
            dc_new = sum5[4];
          end
          default: begin
            wr_w = 1'b0;
            upd_z = 1'b0;
          end
        endcase
      end
    endcase
  end

  // program counter sequencing
  wire [12:0] pc_inc = pc_q + 13'h0001;
  wire [SPW-1:0] sp_top = sp_q - SPW'(1);
  wire [12:0] pc_next = (do_call | do_jump) ? {pc_q[12:11], instr_q[10:0]} :
                        do_pop ? stack_q[sp_top] : skip ? pc_q + 13'h0002 : pc_inc;
  wire pc_jumps = do_call | do_jump | do_pop;
  wire wdt_presc_wrap = (wdt_presc_q == 8'hff);
  wire wdt_step = ~psa_q | wdt_presc_wrap;
  wire wdt_tick = (ph_q == 2'h3) || (state_q == MCD_STANDBY);
  wire wdt_over = wdt_tick & wdt_step & (wdt_q == 8'hff);
  wire exec_now = tick_exec & ~flush_q;

  // pin synchroniser
  always_ff @(posedge mclk_i) begin
    pin_meta_q <= port_pins_i;
    pin_sync_q <= pin_meta_q;
  end

  // APB slave: answer in the first access cycle
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
      run_q <= 1'b0;
      psa_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
      if (apb_setup) begin
        prdata_q <= (hit && !pwrite_i) ? rd_mux : 32'h0;
        pslverr_q <= ~hit;
      end
      if (wr_ctrl) begin
        run_q <= pwdata_i[`MCD_CTRL_RUN];
        psa_q <= pwdata_i[`MCD_CTRL_PSA];
      end
    end
  end

  // sequencer state and phase, stop flag follows the standby state
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_q <= MCD_HALT;
      ph_q <= 2'h0;
      stop_q <= 1'b0;
    end else begin
      case (state_q)
        MCD_HALT: begin
          ph_q <= 2'h0;
          stop_q <= 1'b0;
          if (run_q) state_q <= MCD_RUN;
        end
        MCD_RUN: begin
          ph_q <= ph_q + 2'h1;
          stop_q <= exec_now & go_standby;
          if (exec_now && go_standby) state_q <= MCD_STANDBY;
          else if (ph_q == 2'h3 && !run_q) state_q <= MCD_HALT;
        end
        MCD_STANDBY: begin
          ph_q <= 2'h0;
          stop_q <= ~(wake_req | wdt_over);
          if (wake_req || wdt_over) state_q <= MCD_RUN;
        end
        default: state_q <= MCD_HALT;
      endcase
    end
  end

  // fetch, operand capture, commit
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pc_q <= `MCD_PC_RESET;
      instr_q <= `MCD_NOP_WORD;
      opnd_q <= 8'h00;
      w_q <= 8'h00;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
      flush_q <= 1'b0;
      sp_q <= '0;
    end else begin
      if (tick_fetch) instr_q <= flush_q ? `MCD_NOP_WORD : pm_data_i;
      if (tick_read) opnd_q <= src_byte;
      if (tick_exec) begin
        flush_q <= exec_now & (skip | pc_jumps);
        if (exec_now) begin
          pc_q <= pc_next;
          if (wr_w) w_q <= res;
          if (upd_z) z_q <= (res == 8'h00);
          if (upd_cdc) begin
            c_q <= c_new;
            dc_q <= dc_new;
          end
          if (upd_c) c_q <= c_new;
          if (do_call) sp_q <= sp_q + SPW'(1);
          if (do_pop) sp_q <= sp_top;
        end
      end
    end
  end

  // return stack, circular
  always_ff @(posedge mclk_i) begin
    if (exec_now && do_call) stack_q[sp_q] <= pc_inc;
  end

  // file write port and timer-zero prescaler clear
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      file_addr_q <= 7'h00;
      file_wdata_q <= 8'h00;
      file_we_q <= 1'b0;
      timer_zero_count_clr_q <= 1'b0;
    end else begin
      file_we_q <= exec_now & wr_f;
      timer_zero_count_clr_q <= exec_now & wr_f & (faddr == `MCD_TIMER_ZERO_COUNT_ADDR) & ~psa_q;
      if (tick_fetch) file_addr_q <= pm_data_i[6:0];
      if (exec_now) file_wdata_q <= res;
    end
  end

  // watchdog, power flags, interrupt enable
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wdt_q <= 8'h00;
      wdt_presc_q <= 8'h00;
      to_q <= 1'b1;
      pd_q <= 1'b1;
      gie_q <= 1'b0;
    end else begin
      if (exec_now && wdt_clr) begin
        wdt_q <= 8'h00;
        wdt_presc_q <= 8'h00;
        to_q <= 1'b1;
        pd_q <= ~go_standby;
      end else if (wdt_tick && state_q != MCD_HALT) begin
        if (psa_q) wdt_presc_q <= wdt_presc_q + 8'h01;
        if (wdt_step) wdt_q <= wdt_q + 8'h01;
        if (wdt_over) to_q <= 1'b0;
      end
      if (exec_now && set_gie) gie_q <= 1'b1;
      else if (gie_clr) gie_q <= 1'b0;
    end
  end

  // outputs straight from flip-flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign pm_addr_o = pc_q;
  assign file_addr_o = file_addr_q;
  assign file_wdata_o = file_wdata_q;
  assign file_we_o = file_we_q;
  assign timer_zero_count_presc_clr_o = timer_zero_count_clr_q;
  assign osc_stop_o = stop_q;
  assign global_interrupt_enable_o = gie_q;

endmodule : mcd_core

// *** bench/mcd_core_assertions.sv ***
// Purpose: port checks for mcd_core
// Assumes: zero-wait apb, four clocks per instruction cycle
// Notes: bound from the testbench file
`timescale 1ns/100ps
`include "mcd_defs.svh"
module mcd_core_assertions (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [12:0] pm_addr_o,
  input wire logic [13:0] pm_data_i,
  input wire logic [6:0] file_addr_o,
  input wire logic file_we_o,
  input wire logic timer_zero_count_presc_clr_o,
  input wire logic osc_stop_o,
  input wire logic global_interrupt_enable_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  wire logic mapped_w;
  // decode of the four register words
  assign mapped_w = paddr_i inside {`MCD_OFS_CTRL, `MCD_OFS_STATUS, `MCD_OFS_PC, `MCD_OFS_WDT};
  // apb request steps
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_ctrl_write;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == `MCD_OFS_CTRL;
  endsequence
  AST_PREADY_AFTER_SETUP: assert property (s_setup |=> pready_o)
    else $error("no ready after setup cycle");
  AST_PREADY_SINGLE: assert property (pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  AST_SLVERR_MAP: assert property (pready_o |-> pslverr_o == !mapped_w)
    else $error("error response does not match address map");
  AST_SLVERR_ZERO: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  AST_GIE_SW_CLEAR: assert property (s_ctrl_write ##0 pwdata_i[`MCD_CTRL_GIE_CLR]
    |=> !global_interrupt_enable_o) else $error("interrupt enable not cleared");
  AST_FETCH_SPACING: assert property ($changed(pm_addr_o) |=> $stable(pm_addr_o) [*3])
    else $error("program counter moved inside an instruction cycle");
  AST_GIE_BY_IRET: assert property ($rose(global_interrupt_enable_o)
    |-> $past(pm_data_i, 2) == {6'h00, `MCD_CW_IRET}) else $error("enable set without return");
  AST_STOP_BY_STANDBY: assert property ($rose(osc_stop_o)
    |-> $past(pm_data_i, 2) == {6'h00, `MCD_CW_STANDBY}) else $error("stop without standby");
  AST_PRESC_CLR_TIMER_ZERO_COUNT: assert property (timer_zero_count_presc_clr_o
    |-> file_addr_o == `MCD_TIMER_ZERO_COUNT_ADDR ##1 !timer_zero_count_presc_clr_o) else $error("bad prescaler clear");
  AST_WE_AFTER_COMMIT: assert property (file_we_o
    |-> pm_addr_o != $past(pm_addr_o) ##1 !file_we_o) else $error("file write off commit");
endmodule : mcd_core_assertions

// *** bench/mcd_prog_file_model.sv ***
// Purpose: program memory and file space beside mcd_core
// Assumes: reads are combinational, writes land on the clock edge
// Notes: port latches read 00h so pin reads stand apart
`timescale 1ns/100ps
module mcd_prog_file_model (
  input wire logic clk_i,
  input wire logic [12:0] pm_addr_i,
  output logic [13:0] pm_data_o,
  input wire logic [6:0] file_addr_i,
  output logic [7:0] file_rdata_o,
  input wire logic [7:0] file_wdata_i,
  input wire logic file_we_i
);
  logic [13:0] prog [0:31];
  logic [7:0] ram [0:127];
  // clear both stores
  initial begin
    foreach (prog[i]) prog[i] = 14'h0000;
    foreach (ram[i]) ram[i] = 8'h00;
  end
  // words beyond the store fetch as no-operation
  assign pm_data_o = (pm_addr_i < 13'd32) ? prog[pm_addr_i[4:0]] : 14'h0000;
  assign file_rdata_o = ram[file_addr_i];
  // write on the edge where the strobe is high
  always @(posedge clk_i) begin
    if (file_we_i) begin
      ram[file_addr_i] <= file_wdata_i;
    end
  end
endmodule : mcd_prog_file_model

// *** bench/testbench.sv ***
// Purpose: self-checking bench for mcd_core
// Assumes: zero-wait apb slave, program held in the partner model
// Notes: one program covers every group, then standby and wake
`timescale 1ns/100ps
`include "mcd_defs.svh"
module testbench;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic [39:0] port_pins_i = 40'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, file_we_o, timer_zero_count_presc_clr_o, osc_stop_o, global_interrupt_enable_o;
  logic [12:0] pm_addr_o;
  logic [13:0] pm_data_i;
  logic [6:0] file_addr_o;
  logic [7:0] file_rdata_i, file_wdata_o;
  int fail_count = 0;
  int total_checks = 0;
  int presc_pulses = 0;
  int n;
  logic [64:0] rd_q[$];
  logic [14:0] wr_q[$];
  logic [64:0] rd_e;
  logic [13:0] code [0:19] = '{14'h305a, 14'h00a0, 14'h3ea6, 14'h0da0, 14'h0c20, 14'h08a1,
    14'h2012, 14'h00a2, 14'h14a0, 14'h1c20, 14'h00a3, 14'h0001, 14'h0805, 14'h0081,
    14'h2013, 14'h0064, 14'h0063, 14'h2811, 14'h343c, 14'h0009};

  mcd_core mcd_core_inst (.mclk_i, .reset_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pm_addr_o, .pm_data_i, .file_addr_o,
    .file_rdata_i, .file_wdata_o, .file_we_o, .port_pins_i, .timer_zero_count_presc_clr_o, .osc_stop_o,
    .global_interrupt_enable_o);
  mcd_prog_file_model mcd_prog_file_model_inst (.clk_i(mclk_i), .pm_addr_i(pm_addr_o),
    .pm_data_o(pm_data_i), .file_addr_i(file_addr_o), .file_rdata_o(file_rdata_i),
    .file_wdata_i(file_wdata_o), .file_we_i(file_we_o));

  // 20 MHz clock
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // one apb transfer, entered just after an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) begin
      k++;
      if (k > 16) begin
        fail_count++;
        tally_and_finish();
      end
      @(posedge mclk_i);
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic err);
    rd_q.push_back({m, err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // bounded wait for the stop output to reach a level, cycles left in n
  task automatic wait_stop(input logic want, input int limit);
    n = 0;
    while (osc_stop_o !== want) begin
      @(posedge mclk_i);
      n++;
      if (n > limit) begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask : wait_stop

  // compare each read and each file write with the oldest note
  always @(posedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
      rd_e = rd_q.pop_front();
      check({7'h0, pslverr_o, prdata_o & rd_e[64:33]}, {7'h0, rd_e[32:0]});
    end
    if (file_we_o === 1'b1) begin
      check({25'h0, file_addr_o, file_wdata_o}, {25'h0, wr_q.pop_front()});
    end
    if (timer_zero_count_presc_clr_o === 1'b1) begin
      presc_pulses++;
    end
  end

  // main sequence
  initial begin
    void'($urandom(4));
    repeat (2) @(posedge mclk_i);
    foreach (code[i]) mcd_prog_file_model_inst.prog[i] = code[i];
    port_pins_i <= 40'({$urandom(), $urandom()}) | 40'h1;
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(`MCD_OFS_CTRL, 32'h0, 32'hffffffff, 1'b0);
    rd(`MCD_OFS_STATUS, 32'h1800, 32'hffff, 1'b0);
    rd(8'h10, 32'h0, 32'hffffffff, 1'b1);
    $display("test reset and map done");
    wr_q = '{15'h205a, 15'h20b5, 15'h2100, 15'h223c, 15'h20b7};
    wr_q.push_back({7'h01, port_pins_i[7:0]});
    apb(1'b1, `MCD_OFS_CTRL, 32'h1);
    wait_stop(1'b1, 400);
    check({39'h0, (n >= 84 && n <= 104)}, 40'h1);
    rd(`MCD_OFS_STATUS, 32'h6b00 | port_pins_i[7:0], 32'h7fff, 1'b0);
    check(presc_pulses, 1);
    rd(`MCD_OFS_PC, 32'h11, 32'hffff, 1'b0);
    check({39'h0, global_interrupt_enable_o}, 40'h1);
    check({32'h0, 8'(wr_q.size())}, 40'h0);
    $display("test program run done");
    apb(1'b1, `MCD_OFS_CTRL, 32'h5);
    wait_stop(1'b0, 16);
    apb(1'b1, `MCD_OFS_CTRL, 32'hb);
    rd(`MCD_OFS_STATUS, 32'h0, 32'h2000, 1'b0);
    rd(`MCD_OFS_CTRL, 32'h3, 32'hffffffff, 1'b0);
    check({39'h0, global_interrupt_enable_o}, 40'h0);
    $display("test wake and control done");
    tally_and_finish();
  end
endmodule : testbench

bind mcd_core mcd_core_assertions mcd_core_assertions_inst (.mclk_i, .reset_n_i, .paddr_i,
  .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pm_addr_o,
  .pm_data_i, .file_addr_o, .file_we_o, .timer_zero_count_presc_clr_o, .osc_stop_o,
  .global_interrupt_enable_o);
